/* hdl/uvp_pkg.sv */
/*
 * Constants and types shared by the undervoltage pick-up stage.
 * Assumes all voltages and levels arrive in hundredths of a percent of nominal, except the VT nominal, which arrives in dv.
 */
package uvp_pkg;
    localparam int UVP_VW = 16;
    localparam int UVP_TW = 19;
    localparam int UVP_RW = 18;
    localparam int UVP_PW = 24;
    localparam logic [15:0] UVP_PICKUP_RST = 16'h1770;
    localparam logic [15:0] UVP_BLOCK_RST = 16'h03E8;
    localparam logic [18:0] UVP_DELAY_RST = 19'h00008;
    localparam logic [15:0] UVP_DIAL_RST = 16'h0005;
    localparam logic [6:0] UVP_HYST_PCT = 7'h67;
    localparam logic [6:0] UVP_PCT_DEN = 7'h64;
    localparam logic [6:0] UVP_RATIO_SCALE = 7'h64;
    localparam logic [17:0] UVP_RATIO_MAX = 18'h1E848;
    localparam logic [18:0] UVP_TIME_MAX = 19'h57E40;
    localparam logic [13:0] UVP_PRIM_DEN = 14'h2710;
    localparam logic [1:0] UVP_DIAL_TO_TICK = 2'h2;
    localparam int UVP_TBASE_MS = 5;
    localparam logic [2:0] UVP_JOB_LAST = 3'h7;
    typedef enum logic [1:0] {
        UVP_SEL_PP,
        UVP_SEL_PE,
        UVP_SEL_CH3,
        UVP_SEL_CH4
    } uvp_sel_t;
endpackage

/* hdl/uvp_divider.sv */
/*
 * Serial restoring divider, one quotient bit per clock.
 * Assumes the caller holds operands stable only at the start pulse.
 */
module uvp_divider #(
    parameter int NW = 34,
    parameter int DW = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [NW-1:0] i_num,
    input wire logic [DW-1:0] i_den,
    output logic o_done,
    output logic [NW-1:0] o_quot
);
    logic [NW-1:0] num_q;
    logic [DW-1:0] den_q;
    logic [DW:0] rem_q;
    logic [NW-1:0] quot_q;
    logic [$clog2(NW+1)-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    wire logic [DW:0] trial = {rem_q[DW-1:0], num_q[NW-1]};
    wire logic fits = trial >= {1'b0, den_q};
    wire logic den_zero = den_q == '0;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            quot_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (i_go) begin
                num_q <= i_num;
                den_q <= i_den;
                rem_q <= '0;
                cnt_q <= '0;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                num_q <= {num_q[NW-2:0], 1'b0};
                rem_q <= fits ? trial - {1'b0, den_q} : trial;
                quot_q <= {quot_q[NW-2:0], fits};
                cnt_q <= cnt_q + 1'b1;
                if (32'(cnt_q) == NW - 1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    // a zero divisor saturates so callers can clamp instead of special-casing
    assign o_quot = den_zero ? '1 : quot_q;
    assign o_done = done_q;
endmodule

/* hdl/uvp_stage.sv */
/*
 * Undervoltage pick-up, hysteresis, de-energized block and live status values.
 * Assumes a measurement front end that strobes i_meas_valid every 5 ms with
 * voltages in hundredths of a percent of nominal, and settings loaded by strobe.
 */
module uvp_stage (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_meas_valid,
    input wire logic [uvp_pkg::UVP_VW-1:0] i_volt_pp [3],
    input wire logic [uvp_pkg::UVP_VW-1:0] i_volt_pe [3],
    input wire logic [uvp_pkg::UVP_VW-1:0] i_volt_ch3,
    input wire logic [uvp_pkg::UVP_VW-1:0] i_volt_ch4,
    input wire logic i_set_load,
    input wire logic [uvp_pkg::UVP_VW-1:0] i_pickup_set,
    input wire logic [uvp_pkg::UVP_VW-1:0] i_block_set,
    input wire uvp_pkg::uvp_sel_t i_sel,
    input wire logic i_inverse_time_mode,
    input wire logic [uvp_pkg::UVP_TW-1:0] i_delay_set,
    input wire logic [15:0] i_dial_set,
    input wire logic [uvp_pkg::UVP_PW-1:0] i_vt_nominal_dv,
    input wire logic i_ext_block,
    output logic o_pickup,
    output logic o_start,
    output logic o_blocked,
    output logic o_deenergized_block,
    output logic [uvp_pkg::UVP_PW-1:0] o_pickup_primary_dv,
    output logic [uvp_pkg::UVP_PW-1:0] o_block_primary_dv,
    output logic [uvp_pkg::UVP_RW-1:0] o_ratio_set_meas [3],
    output logic [uvp_pkg::UVP_RW-1:0] o_ratio_meas_set [3],
    output logic [uvp_pkg::UVP_RW-1:0] o_ratio_min,
    output logic [uvp_pkg::UVP_TW-1:0] o_expected_time,
    output logic signed [uvp_pkg::UVP_TW:0] o_remaining_time
);
    import uvp_pkg::*;

    logic [UVP_VW-1:0] pickup_q, block_q, dial_q;
    logic [UVP_TW-1:0] delay_q, expected_q, elapsed_q, inv_time_q;
    uvp_sel_t sel_q;
    logic inv_mode_q;
    logic active_q, start_q, blocked_q, deen_q;
    logic [UVP_VW-1:0] volt_q [3];
    logic [UVP_VW-1:0] vmin_q;
    logic [UVP_RW-1:0] rsm_q [3], rms_q [3], rmin_q;
    logic [UVP_PW-1:0] pprim_q, bprim_q;
    logic [2:0] job_q;
    logic run_q, go_q;
    logic signed [UVP_TW:0] remain_q;

    logic [UVP_VW-1:0] sup [3];
    logic [2:0] below_set, below_blk, above_rel, above_set;
    wire logic [UVP_VW+6:0] rel_wide = pickup_q * UVP_HYST_PCT / UVP_PCT_DEN;
    wire logic [UVP_VW:0] release_lvl = rel_wide[UVP_VW:0];
    wire logic [UVP_VW-1:0] vmin_a = (sup[0] < sup[1]) ? sup[0] : sup[1];
    wire logic [UVP_VW-1:0] vmin_now = (vmin_a < sup[2]) ? vmin_a : sup[2];

    // supervised channel selection and per-voltage comparators
    for (genvar g = 0; g < 3; g++) begin : g_ch
        assign sup[g] = (sel_q == UVP_SEL_PP) ? i_volt_pp[g] :
                        (sel_q == UVP_SEL_PE) ? i_volt_pe[g] :
                        (sel_q == UVP_SEL_CH3) ? i_volt_ch3 : i_volt_ch4;
        assign below_set[g] = sup[g] < pickup_q;
        assign below_blk[g] = sup[g] < block_q;
        assign above_rel[g] = {1'b0, sup[g]} > release_lvl;
        assign above_set[g] = sup[g] > pickup_q;
    end

    wire logic any_below = |below_set;
    wire logic blk_on = block_q != '0;
    wire logic pickup_d = active_q ? ~&above_rel : any_below;
    wire logic deen_d = blk_on & (deen_q ? ~&above_set : |below_blk);
    wire logic rise = pickup_d & ~active_q;
    // blocked wins when the external block is present at the pick-up moment
    wire logic blocked_d = pickup_d & (rise ? i_ext_block : blocked_q);
    wire logic start_d = pickup_d & ~blocked_d & ~deen_d & ~i_ext_block;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pickup_q <= UVP_PICKUP_RST;
            block_q <= UVP_BLOCK_RST;
            sel_q <= UVP_SEL_PP;
            inv_mode_q <= 1'b0;
            delay_q <= UVP_DELAY_RST;
            dial_q <= UVP_DIAL_RST;
        end else if (i_set_load) begin
            pickup_q <= i_pickup_set;
            block_q <= i_block_set;
            sel_q <= i_sel;
            inv_mode_q <= i_inverse_time_mode;
            delay_q <= i_delay_set;
            dial_q <= i_dial_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            active_q <= 1'b0;
            start_q <= 1'b0;
            blocked_q <= 1'b0;
            deen_q <= 1'b0;
            elapsed_q <= '0;
        end else if (i_meas_valid) begin
            active_q <= pickup_d;
            start_q <= start_d;
            blocked_q <= blocked_d;
            deen_q <= deen_d;
            elapsed_q <= start_d ? elapsed_q + 1'b1 : '0;
        end else if (!blk_on) begin
            deen_q <= 1'b0;
        end
    end

    // ratio and time jobs share one serial divider, far inside the 5 ms budget
    wire logic [1:0] jch = job_q[1:0] == 2'h3 ? 2'h0 : job_q[1:0];
    wire logic [UVP_VW-1:0] jv = volt_q[jch];
    wire logic [UVP_VW-1:0] inv_den = (vmin_q < pickup_q) ? pickup_q - vmin_q : '0;
    logic [33:0] num;
    logic [15:0] den;
    always_comb begin
        num = '0;
        den = pickup_q;
        // operands widened first: the 16-bit products would otherwise wrap
        if (job_q < 3'h3) begin
            num = 34'(pickup_q) * 34'(UVP_RATIO_SCALE);
            den = jv;
        end else if (job_q < 3'h6) begin
            num = 34'(volt_q[2'(job_q - 3'h3)]) * 34'(UVP_RATIO_SCALE);
        end else if (job_q == 3'h6) begin
            num = 34'(vmin_q) * 34'(UVP_RATIO_SCALE);
        end else begin
            // inverse time with unit exponent: k * set / (set - measured)
            num = 34'(dial_q) * 34'(UVP_DIAL_TO_TICK) * 34'(pickup_q);
            den = inv_den;
        end
    end

    logic div_done;
    logic [33:0] quot;
    uvp_divider #(.NW(34), .DW(16)) u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_go(go_q),
        .i_num(num),
        .i_den(den),
        .o_done(div_done),
        .o_quot(quot)
    );
    wire logic [UVP_RW-1:0] qr = (quot > 34'(UVP_RATIO_MAX)) ? UVP_RATIO_MAX : quot[UVP_RW-1:0];
    wire logic [UVP_TW-1:0] qt = (quot > 34'(UVP_TIME_MAX)) ? UVP_TIME_MAX : quot[UVP_TW-1:0];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_q <= 1'b0;
            go_q <= 1'b0;
            job_q <= '0;
            vmin_q <= '0;
            inv_time_q <= '0;
            rmin_q <= '0;
            for (int i = 0; i < 3; i++) begin
                volt_q[i] <= '0;
                rsm_q[i] <= '0;
                rms_q[i] <= '0;
            end
        end else begin
            go_q <= 1'b0;
            if (i_meas_valid) begin
                for (int i = 0; i < 3; i++) volt_q[i] <= sup[i];
                vmin_q <= vmin_now;
                job_q <= '0;
                run_q <= 1'b1;
                go_q <= 1'b1;
            end else if (run_q && div_done) begin
                if (job_q < 3'h3) rsm_q[job_q[1:0]] <= qr;
                else if (job_q < 3'h6) rms_q[2'(job_q - 3'h3)] <= qr;
                else if (job_q == 3'h6) rmin_q <= qr;
                else inv_time_q <= qt;
                if (job_q == UVP_JOB_LAST) begin
                    run_q <= 1'b0;
                end else begin
                    job_q <= job_q + 1'b1;
                    go_q <= 1'b1;
                end
            end
        end
    end

    wire logic [UVP_PW+15:0] pp_w = pickup_q * i_vt_nominal_dv / UVP_PRIM_DEN;
    wire logic [UVP_PW+15:0] bp_w = block_q * i_vt_nominal_dv / UVP_PRIM_DEN;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pprim_q <= '0;
            bprim_q <= '0;
            expected_q <= '0;
            remain_q <= '0;
        end else begin
            pprim_q <= pp_w[UVP_PW-1:0];
            bprim_q <= bp_w[UVP_PW-1:0];
            expected_q <= inv_mode_q ? inv_time_q : delay_q;
            remain_q <= start_q ? $signed({1'b0, expected_q}) - $signed({1'b0, elapsed_q})
                                : '0;
        end
    end

    assign o_pickup = active_q;
    assign o_start = start_q;
    assign o_blocked = blocked_q;
    assign o_deenergized_block = deen_q;
    assign o_pickup_primary_dv = pprim_q;
    assign o_block_primary_dv = bprim_q;
    assign o_ratio_set_meas = rsm_q;
    assign o_ratio_meas_set = rms_q;
    assign o_ratio_min = rmin_q;
    assign o_expected_time = expected_q;
    assign o_remaining_time = remain_q;

    AST_START_GATED:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_start |-> o_pickup && !o_blocked && !o_deenergized_block)
        else $error("start without clean pick-up");
    AST_BLOCKED_AT_RISE:
    assert property (@(posedge i_clk) disable iff (i_rst)
        i_meas_valid && !o_pickup && any_below && i_ext_block |=> o_blocked && !o_start)
        else $error("external block at pick-up did not give blocked");
    AST_PICKUP_SET:
    assert property (@(posedge i_clk) disable iff (i_rst)
        i_meas_valid && any_below && !i_set_load |=> o_pickup)
        else $error("voltage below threshold did not pick up");
    AST_HYST_HOLD:
    assert property (@(posedge i_clk) disable iff (i_rst)
        i_meas_valid && o_pickup && !(&above_rel) && !i_set_load |=> o_pickup)
        else $error("pick-up released below release level");
    AST_DEEN_LATCH:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_deenergized_block && blk_on && i_meas_valid && !(&above_set) && !i_set_load
        |=> o_deenergized_block)
        else $error("de-energized block left before recovery");
    AST_DEEN_OFF:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !blk_on && !i_set_load |=> !o_deenergized_block)
        else $error("block active with zero level");
    AST_JOBS_BOUNDED:
    assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(run_q) |-> ##[280:300] !run_q)
        else $error("ratio jobs not finished in time");
    AST_FIXED_TIME:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !inv_mode_q && !i_set_load ##1 !inv_mode_q |-> o_expected_time == $past(delay_q))
        else $error("fixed delay mode time mismatch");
    AST_REMAIN_ZERO:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !o_start |=> o_remaining_time == 0)
        else $error("remaining time outside timing");
    CVR_START: cover property (@(posedge i_clk) $rose(o_start));
    CVR_BLOCKED: cover property (@(posedge i_clk) $rose(o_blocked));
    CVR_DEEN: cover property (@(posedge i_clk) $fell(o_deenergized_block) && blk_on);
endmodule

/* hdl/uvp_unused_guard_none.sv */
/*
 * Holds no logic: the stage and its divider live in their own files.
 * Assumes nothing of its surroundings.
 */

/* test/uvp_meas_model.sv */
/*
 * Behavioural measurement front end and voltage source for the undervoltage stage.
 * Assumes the bench requests one update at a time, far enough apart for all jobs.
 */
module uvp_meas_model (
    input wire logic i_clk,
    input wire logic i_fire,
    input wire logic [1:0] i_src,
    input wire logic [uvp_pkg::UVP_VW-1:0] i_v [3],
    output logic o_meas_valid,
    output logic [uvp_pkg::UVP_VW-1:0] o_volt_pp [3],
    output logic [uvp_pkg::UVP_VW-1:0] o_volt_pe [3],
    output logic [uvp_pkg::UVP_VW-1:0] o_volt_ch3,
    output logic [uvp_pkg::UVP_VW-1:0] o_volt_ch4
);
    timeunit 1ns;
    timeprecision 100ps;
    import uvp_pkg::*;
    // sources not under test sit at nominal, so only the chosen one can pick up
    localparam logic [15:0] NOM = 16'h2710;
    logic [15:0] v_q [3] = '{16'h2710, 16'h2710, 16'h2710};
    logic [1:0] src_q = 2'h0;
    always_ff @(posedge i_clk) begin
        o_meas_valid <= i_fire;
        if (i_fire) begin
            v_q <= i_v;
            src_q <= i_src;
        end
    end
    for (genvar g = 0; g < 3; g++) begin : g_ch
        assign o_volt_pp[g] = (src_q == 2'h0) ? v_q[g] : NOM;
        assign o_volt_pe[g] = (src_q == 2'h1) ? v_q[g] : NOM;
    end
    assign o_volt_ch3 = (src_q == 2'h2) ? v_q[0] : NOM;
    assign o_volt_ch4 = (src_q == 2'h3) ? v_q[0] : NOM;
endmodule

/* test/uvp_stage_tb.sv */
/*
 * Self-checking bench for the undervoltage pick-up stage.
 * Assumes the measurement model in uvp_meas_model and settings driven directly.
 */
module uvp_stage_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import uvp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fire = 1'b0;
    logic [1:0] src = 2'h0;
    logic [15:0] v [3] = '{16'h2710, 16'h2710, 16'h2710};
    logic meas_valid;
    logic [15:0] pp [3];
    logic [15:0] pe [3];
    logic [15:0] ch3;
    logic [15:0] ch4;
    logic set_load = 1'b0;
    logic [15:0] pickup_set = 16'h1770;
    logic [15:0] block_set = 16'h03E8;
    uvp_sel_t sel = UVP_SEL_PP;
    logic inv = 1'b0;
    logic ext = 1'b0;
    logic [18:0] delay_set = 19'h00008;
    logic [15:0] dial_set = 16'h0005;
    logic [23:0] vt_dv = 24'h01ADB0;
    logic pickup, start, blocked, deen;
    logic [23:0] pu_dv, bl_dv;
    logic [17:0] r_sm [3];
    logic [17:0] r_ms [3];
    logic [17:0] r_min;
    logic [18:0] exp_t;
    logic signed [19:0] rem_t;
    int err_total = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    uvp_meas_model i_uvp_meas_model (.i_clk(clk), .i_fire(fire), .i_src(src), .i_v(v),
        .o_meas_valid(meas_valid), .o_volt_pp(pp), .o_volt_pe(pe), .o_volt_ch3(ch3),
        .o_volt_ch4(ch4));

    uvp_stage i_uvp_stage (.i_clk(clk), .i_rst(rst), .i_meas_valid(meas_valid),
        .i_volt_pp(pp), .i_volt_pe(pe), .i_volt_ch3(ch3), .i_volt_ch4(ch4),
        .i_set_load(set_load), .i_pickup_set(pickup_set), .i_block_set(block_set),
        .i_sel(sel), .i_inverse_time_mode(inv), .i_delay_set(delay_set),
        .i_dial_set(dial_set), .i_vt_nominal_dv(vt_dv), .i_ext_block(ext),
        .o_pickup(pickup), .o_start(start), .o_blocked(blocked),
        .o_deenergized_block(deen), .o_pickup_primary_dv(pu_dv), .o_block_primary_dv(bl_dv),
        .o_ratio_set_meas(r_sm), .o_ratio_meas_set(r_ms), .o_ratio_min(r_min),
        .o_expected_time(exp_t), .o_remaining_time(rem_t));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic load(input logic [15:0] pu, input logic [15:0] bl, input logic [1:0] s,
                        input logic im);
        pickup_set = pu;
        block_set = bl;
        sel = uvp_sel_t'(s);
        inv = im;
        set_load = 1'b1;
        tick(1);
        set_load = 1'b0;
    endtask

    // waits long enough for every divider job of the update to land
    task automatic meas(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                        input logic [1:0] s);
        v = '{a, b, c};
        src = s;
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        tick(320);
    endtask

    task automatic t_defaults();
        chk("pickup", pickup, 0);
        chk("deen", deen, 0);
        chk("pu_dv", pu_dv, 66000);
        chk("bl_dv", bl_dv, 11000);
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        chk("pickup", pickup, 0);
        chk("r_ms0", r_ms[0], 166);
        chk("r_sm0", r_sm[0], 60);
    endtask

    task automatic t_hyst();
        meas(16'h176F, 16'h2710, 16'h2710, 2'h0);
        chk("pickup", pickup, 1);
        chk("start", start, 1);
        chk("exp_t", exp_t, 8);
        chk("rem_t", rem_t, 7);
        meas(16'h1824, 16'h2710, 16'h2710, 2'h0);
        chk("pickup", pickup, 1);
        meas(16'h1825, 16'h2710, 16'h2710, 2'h0);
        chk("pickup", pickup, 0);
        chk("rem_t", rem_t, 0);
    endtask

    task automatic t_deen();
        meas(16'h0384, 16'h2710, 16'h2710, 2'h0);
        chk("deen", deen, 1);
        chk("start", start, 0);
        meas(16'h1770, 16'h2710, 16'h2710, 2'h0);
        chk("deen_hold", deen, 1);
        meas(16'h17D4, 16'h17D4, 16'h17D4, 2'h0);
        chk("deen", deen, 0);
        chk("pickup", pickup, 1);
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        load(16'h1770, 16'h0000, 2'h0, 1'b0);
        meas(16'h01F4, 16'h2710, 16'h2710, 2'h0);
        chk("deen", deen, 0);
        chk("start", start, 1);
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        load(16'h1770, 16'h03E8, 2'h0, 1'b0);
    endtask

    task automatic t_ext();
        ext = 1'b1;
        meas(16'h1388, 16'h2710, 16'h2710, 2'h0);
        chk("blocked", blocked, 1);
        chk("start", start, 0);
        ext = 1'b0;
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        chk("blocked", blocked, 0);
    endtask

    task automatic t_sel();
        for (int s = 0; s < 4; s++) begin
            load(16'h1770, 16'h03E8, 2'(s), 1'b0);
            meas(16'h1388, 16'h2710, 16'h2710, 2'(s));
            chk("pickup_sel", pickup, 1);
            meas(16'h1388, 16'h2710, 16'h2710, 2'(s + 1));
            chk("pickup_other", pickup, 0);
        end
    endtask

    task automatic t_ratio();
        load(16'h1770, 16'h03E8, 2'h0, 1'b1);
        meas(16'h0BB8, 16'h1770, 16'h2328, 2'h0);
        chk("r_sm0", r_sm[0], 200);
        chk("r_ms1", r_ms[1], 100);
        chk("r_ms2", r_ms[2], 150);
        chk("r_min", r_min, 50);
        chk("exp_t", exp_t, 20);
        chk("r_sm1", r_sm[1], 100);
        chk("r_sm2", r_sm[2], 66);
        chk("r_ms0", r_ms[0], 50);
        meas(16'h1194, 16'h1770, 16'h2328, 2'h0);
        chk("exp_t_track", exp_t, 40);
        chk("r_min_track", r_min, 75);
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        delay_set = 19'h0000C;
        load(16'h1770, 16'h03E8, 2'h0, 1'b0);
        meas(16'h1388, 16'h2710, 16'h2710, 2'h0);
        chk("exp_t_fixed", exp_t, 12);
        chk("rem_t_fixed", rem_t, 11);
        meas(16'h2710, 16'h2710, 16'h2710, 2'h0);
        vt_dv = 24'h002710;
        tick(1);
        chk("pu_dv_vt", pu_dv, 6000);
        chk("bl_dv_vt", bl_dv, 1000);
    endtask

    task automatic results();
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        tick(3);
        rst = 1'b0;
        tick(1);
        t_defaults();
        t_hyst();
        t_deen();
        t_ext();
        t_sel();
        t_ratio();
        results();
    end
endmodule
